// file: rtl/pmt_table_read.sv
// program memory with fetch, table reads and serial programming access
// assumes a core that steps one instruction per sys_clk and obeys tableStall
//
// Notes on behaviour
// R1 - program memory is 1K words of 14 bits or 2K words of 15 bits by variant.
// R2 - after any reset the first fetch comes from address 000H.
// R3 - a full table address joins the low and high pointer registers.
// R4 - a table read writes the low byte of the word to the operand register.
// R5 - the upper part of the word goes to the high byte register, unused bits zero.
// R6 - software writes never change the high byte register.
// R7 - every table read takes two instruction cycles.
// R8 - the page mode adds the low pointer to the start of the current page.
// R9 - while the programmer holds reset low, normal work stops and the pins are its.
// R10 - programming data moves both ways on one pin clocked by the programmer.
// R11 - program memory and EEPROM are both written and read over the serial link.
// R12 - writing the low program counter byte jumps within the page with one dummy cycle.
// R13 - fetch is suspended during the extra table cycle and then resumes.
// R14 - both table pointer registers clear on reset.
`timescale 1ns/1ps
`include "pmt_params.svh"

module pmt_table_read #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic externalResetPinN,
  output logic [14:0] fetchWord,
  output logic [10:0] fetchAddr,
  output logic fetchValid,
  output logic tableStall,
  output logic progMode,
  input wire logic jumpEn,
  input wire logic [10:0] jumpAddr,
  input wire logic tblRdReq,
  input wire pmt_pkg::pmt_mode_t tblRdMode,
  input wire logic [7:0] tblDestAddr,
  output logic dmWrEn,
  output logic [7:0] dmWrAddr,
  output logic [7:0] dmWrData,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdAddr,
  output logic [7:0] sfrRdData,
  input wire logic progClockPin,
  input wire logic progDataPinIn,
  output logic progDataPinOut,
  output logic progDataPinOe,
  output logic eeWrEn,
  output logic [7:0] eeAddr,
  output logic [7:0] eeWrData,
  input wire logic [7:0] eeRdData
);

  localparam logic [10:0] ADDR_MASK =
    LARGE_VARIANT ? `PMT_ADDR_MASK_LARGE : `PMT_ADDR_MASK_SMALL;
  localparam logic [14:0] WORD_MASK =
    LARGE_VARIANT ? `PMT_WORD_MASK_LARGE : `PMT_WORD_MASK_SMALL;

  pmt_pkg::pmt_state_t state_reg;
  logic rstPin1_reg, rstPin2_reg;
  logic [10:0] pc_reg, tblAddr_reg, tblAddr_next;
  logic [7:0] ptrLow_reg, tblDest_reg, tblHigh_reg;
  logic [2:0] ptrHigh_reg, pcPage;
  logic [14:0] fetchWord_reg, fetchRaw, tblWord;
  logic [10:0] fetchAddr_reg, fullAddr, pageAddr;
  logic fetchValid_reg, dmWrEn_reg, eeWrEn_reg;
  logic [7:0] dmWrAddr_reg, dmWrData_reg, sfrRdData_reg, eeWrData_reg, tblWordLow;
  logic progReq, inRun, inTable, pcLowWr;
  logic memWrEn;
  logic [14:0] mem [0:2047];
  logic linkWrStb, linkSpace;
  logic [10:0] linkAddr;
  logic [15:0] linkData, linkRdWord;

  // -----------------------------------------------------------------
  // reset pin and control state
  // -----------------------------------------------------------------
  // reset pin crosses in through two flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rstPin1_reg <= 1'b1;
      rstPin2_reg <= 1'b1;
    end else begin
      rstPin1_reg <= externalResetPinN;
      rstPin2_reg <= rstPin1_reg;
    end
  end

  assign progReq = !rstPin2_reg;
  assign inRun = (state_reg == pmt_pkg::PMT_RUN);
  assign inTable = (state_reg == pmt_pkg::PMT_TABLE);
  assign pcLowWr = sfrWrEn && (sfrWrAddr == `PMT_OFS_PC_LOW);
  assign pcPage = fetchAddr_reg[10:8];
  assign tableStall = inTable;
  assign progMode = (state_reg == pmt_pkg::PMT_PROG);

  // R9 - reset pin low holds the core in programming
  // R7 - table read adds one state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= pmt_pkg::PMT_RUN;
    end else if (progReq) begin
      state_reg <= pmt_pkg::PMT_PROG;
    end else begin
      unique case (state_reg)
        pmt_pkg::PMT_RUN: begin
          if (tblRdReq) begin
            state_reg <= pmt_pkg::PMT_TABLE;
          end
        end
        pmt_pkg::PMT_TABLE: state_reg <= pmt_pkg::PMT_RUN;
        pmt_pkg::PMT_PROG: state_reg <= pmt_pkg::PMT_RUN;
        default: state_reg <= pmt_pkg::PMT_RUN;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  // R1 - one word per entry, small variant aliases by mask
  for (genvar i = 0; i < 2048; i++) begin : g_mem
    always_ff @(posedge sys_clk) begin
      if (memWrEn && ((linkAddr & ADDR_MASK) == 11'(i))) begin
        mem[i] <= linkData[14:0] & WORD_MASK;
      end
    end
  end

  assign fetchRaw = mem[pc_reg] & WORD_MASK;
  assign tblWord = mem[tblAddr_reg] & WORD_MASK;
  assign tblWordLow = tblWord[7:0];

  // -----------------------------------------------------------------
  // program counter and fetch
  // -----------------------------------------------------------------
  // R2 - any reset returns to the vector
  // R12 - low byte write stays in the current page
  always_ff @(posedge sys_clk) begin
    if (rst || progReq) begin
      pc_reg <= `PMT_RESET_VECTOR;
    end else if (inRun) begin
      if (jumpEn) begin
        pc_reg <= jumpAddr & ADDR_MASK;
      end else if (pcLowWr) begin
        pc_reg <= {pcPage, sfrWrData} & ADDR_MASK;
      end else begin
        pc_reg <= (pc_reg + 11'd1) & ADDR_MASK;
      end
    end
  end

  // R13 - fetch only in the run state
  // R12 - the word already fetched is dropped as a dummy
  always_ff @(posedge sys_clk) begin
    if (rst || progReq) begin
      fetchWord_reg <= 15'h0000;
      fetchAddr_reg <= `PMT_RESET_VECTOR;
      fetchValid_reg <= 1'b0;
    end else if (inRun) begin
      fetchWord_reg <= fetchRaw;
      fetchAddr_reg <= pc_reg;
      fetchValid_reg <= !(jumpEn || pcLowWr);
    end else begin
      fetchValid_reg <= 1'b0;
    end
  end

  assign fetchWord = fetchWord_reg;
  assign fetchAddr = fetchAddr_reg;
  assign fetchValid = fetchValid_reg;

  // -----------------------------------------------------------------
  // table pointers
  // -----------------------------------------------------------------
  // R14 - pointers clear on reset
  always_ff @(posedge sys_clk) begin
    if (rst || progReq) begin
      ptrLow_reg <= `PMT_PTR_RESET;
      ptrHigh_reg <= 3'(`PMT_PTR_RESET);
    end else if (sfrWrEn) begin
      if (sfrWrAddr == `PMT_OFS_PTR_LOW) begin
        ptrLow_reg <= sfrWrData;
      end
      if (sfrWrAddr == `PMT_OFS_PTR_HIGH) begin
        ptrHigh_reg <= sfrWrData[2:0] & ADDR_MASK[10:8];
      end
    end
  end

  assign fullAddr = {ptrHigh_reg, ptrLow_reg};
  assign pageAddr = {pcPage, ptrLow_reg};

  // R3 - pointer pair forms the address
  // R8 - page mode offsets from the current page
  always_comb begin
    unique case (tblRdMode)
      pmt_pkg::PMT_MODE_FULL: tblAddr_next = fullAddr;
      pmt_pkg::PMT_MODE_PAGE: tblAddr_next = pageAddr;
      pmt_pkg::PMT_MODE_LAST: tblAddr_next = {`PMT_LAST_PAGE, ptrLow_reg};
      default: tblAddr_next = fullAddr;
    endcase
  end

  // address latched so pointer writes during the stall cannot disturb it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tblAddr_reg <= `PMT_RESET_VECTOR;
      tblDest_reg <= 8'h00;
    end else if (inRun && tblRdReq && !progReq) begin
      tblAddr_reg <= tblAddr_next & ADDR_MASK;
      tblDest_reg <= tblDestAddr;
    end
  end

  // -----------------------------------------------------------------
  // table results
  // -----------------------------------------------------------------
  // R4 - low byte to operand register
  // R5 - high part zero padded
  // R6 - only a table read loads the high byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dmWrEn_reg <= 1'b0;
      dmWrAddr_reg <= 8'h00;
      dmWrData_reg <= 8'h00;
      tblHigh_reg <= `PMT_HIGH_RESET;
    end else begin
      dmWrEn_reg <= inTable && !progReq;
      if (inTable && !progReq) begin
        dmWrAddr_reg <= tblDest_reg;
        dmWrData_reg <= tblWordLow;
        tblHigh_reg <= {1'b0, tblWord[14:8]};
      end
    end
  end

  assign dmWrEn = dmWrEn_reg;
  assign dmWrAddr = dmWrAddr_reg;
  assign dmWrData = dmWrData_reg;

  // register read port, one cycle late; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sfrRdData_reg <= 8'h00;
    end else if (sfrRdEn) begin
      unique case (sfrRdAddr)
        `PMT_OFS_PC_LOW: sfrRdData_reg <= fetchAddr_reg[7:0];
        `PMT_OFS_PTR_LOW: sfrRdData_reg <= ptrLow_reg;
        `PMT_OFS_TBL_HIGH: sfrRdData_reg <= tblHigh_reg;
        `PMT_OFS_PTR_HIGH: sfrRdData_reg <= {5'h00, ptrHigh_reg};
        default: sfrRdData_reg <= 8'h00;
      endcase
    end
  end

  assign sfrRdData = sfrRdData_reg;

  // -----------------------------------------------------------------
  // serial programming access
  // -----------------------------------------------------------------
  // R11 - both memories reachable from the link
  assign linkRdWord = linkSpace ? {8'h00, eeRdData} : {1'b0, mem[linkAddr & ADDR_MASK] & WORD_MASK};
  assign memWrEn = linkWrStb && !linkSpace && progMode;

  // R10 - one data pin, programmer clock
  pmt_icp_link u_link (
    .sys_clk(sys_clk),
    .rst(rst),
    .linkActive(progMode),
    .progClockPin(progClockPin),
    .progDataPinIn(progDataPinIn),
    .progDataPinOut(progDataPinOut),
    .progDataPinOe(progDataPinOe),
    .rdWord(linkRdWord),
    .wrStb(linkWrStb),
    .reqSpace(linkSpace),
    .reqAddr(linkAddr),
    .wrData(linkData)
  );

  // R11 - eeprom write strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eeWrEn_reg <= 1'b0;
      eeWrData_reg <= 8'h00;
    end else begin
      eeWrEn_reg <= linkWrStb && linkSpace && progMode;
      eeWrData_reg <= linkData[7:0];
    end
  end

  assign eeWrEn = eeWrEn_reg;
  assign eeWrData = eeWrData_reg;
  assign eeAddr = linkAddr[7:0];

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence tblStart;
    inRun && tblRdReq && !progReq;
  endsequence
  sequence tblBody;
    inTable && !progReq ##1 (dmWrEn_reg && !fetchValid_reg && inRun);
  endsequence
  sequence leaveProg;
    progMode ##1 inRun;
  endsequence

  reset_vector_a: assert property ( // R2
    leaveProg |=> fetchValid_reg && fetchAddr_reg == `PMT_RESET_VECTOR)
    else $error("first fetch after reset not at vector");
  table_two_cycle_a: assert property (tblStart |=> tblBody) // R7
    else $error("table read not two cycles");
  fetch_suspend_a: assert property ( // R13
    inTable && !progReq |=> !fetchValid_reg && $stable(pc_reg))
    else $error("fetch not suspended in table cycle");
  full_address_a: assert property ( // R3
    tblStart and tblRdMode == pmt_pkg::PMT_MODE_FULL |=>
      tblAddr_reg == ($past(fullAddr) & ADDR_MASK))
    else $error("full table address wrong");
  page_address_a: assert property ( // R8
    tblStart and tblRdMode == pmt_pkg::PMT_MODE_PAGE |=>
      tblAddr_reg == ($past(pageAddr) & ADDR_MASK))
    else $error("page table address wrong");
  low_byte_a: assert property ( // R4
    dmWrEn_reg |-> dmWrAddr_reg == $past(tblDest_reg) && dmWrData_reg == $past(tblWordLow))
    else $error("table low byte wrong");
  high_zero_a: assert property ( // R5
    dmWrEn_reg |-> tblHigh_reg[6:0] == $past(tblWord[14:8]) && !tblHigh_reg[7])
    else $error("table high byte wrong");
  high_readonly_a: assert property ( // R6
    !inTable |=> $stable(tblHigh_reg))
    else $error("high byte changed without table read");
  word_width_a: assert property ((fetchWord_reg & ~WORD_MASK) == 15'h0000) // R1
    else $error("fetch word wider than memory");
  page_jump_a: assert property ( // R12
    pcLowWr && inRun && !jumpEn && !tblRdReq && !progReq |=> !fetchValid_reg ##1
      ($past(progReq) || fetchAddr_reg == ({$past(pcPage, 2), $past(sfrWrData, 2)} & ADDR_MASK)))
    else $error("low byte jump wrong");
  prog_hold_a: assert property (progMode |-> !fetchValid_reg && !dmWrEn_reg) // R9
    else $error("core active in programming mode");

endmodule

// file: rtl/pmt_params.svh
// constants of the program memory table-read block
// assumes inclusion by bare name from every design file that needs them
`ifndef PMT_PARAMS_SVH
`define PMT_PARAMS_SVH

// -----------------------------------------------------------------
// memory shape per variant
// -----------------------------------------------------------------
`define PMT_ADDR_MASK_SMALL 11'h3FF
`define PMT_ADDR_MASK_LARGE 11'h7FF
`define PMT_WORD_MASK_SMALL 15'h3FFF
`define PMT_WORD_MASK_LARGE 15'h7FFF
`define PMT_LAST_PAGE 3'h7

// -----------------------------------------------------------------
// special function register offsets and reset values
// -----------------------------------------------------------------
`define PMT_OFS_PC_LOW 8'h06
`define PMT_OFS_PTR_LOW 8'h07
`define PMT_OFS_TBL_HIGH 8'h08
`define PMT_OFS_PTR_HIGH 8'h09
`define PMT_RESET_VECTOR 11'h000
`define PMT_PTR_RESET 8'h00
`define PMT_HIGH_RESET 8'h00

// -----------------------------------------------------------------
// serial programming frame
// -----------------------------------------------------------------
`define PMT_HDR_BITS 5'd13
`define PMT_FRAME_BITS 5'd29

`endif

// file: rtl/pmt_pkg.sv
// types of the program memory table-read block
// assumes nothing of its surroundings
package pmt_pkg;

  // control states, one-hot
  typedef enum logic [2:0] {
    PMT_RUN = 3'b001,
    PMT_TABLE = 3'b010,
    PMT_PROG = 3'b100
  } pmt_state_t;

  // table read addressing modes
  typedef enum logic [1:0] {
    PMT_MODE_FULL = 2'h0,
    PMT_MODE_PAGE = 2'h1,
    PMT_MODE_LAST = 2'h2
  } pmt_mode_t;

endpackage

// file: rtl/pmt_icp_link.sv
// serial programming link: header of 13 bits, then 16 data bits lsb first
// assumes pins are asynchronous to sys_clk and the link clock is slow
`timescale 1ns/1ps
`include "pmt_params.svh"

module pmt_icp_link (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic linkActive,
  input wire logic progClockPin,
  input wire logic progDataPinIn,
  output logic progDataPinOut,
  output logic progDataPinOe,
  input wire logic [15:0] rdWord,
  output logic wrStb,
  output logic reqSpace,
  output logic [10:0] reqAddr,
  output logic [15:0] wrData
);

  logic clk1_reg, clk2_reg, clk3_reg, dat1_reg, dat2_reg;
  logic [4:0] cnt_reg;
  logic [12:0] hdr_reg;
  logic [15:0] dat_reg, out_reg;
  logic oe_reg, hdrDone_reg, wrStb_reg;
  logic rise, reqRead;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  // clock and data take the same delay, so a sample stays aligned
  always_ff @(posedge sys_clk) begin
    clk1_reg <= progClockPin;
    clk2_reg <= clk1_reg;
    clk3_reg <= clk2_reg;
    dat1_reg <= progDataPinIn;
    dat2_reg <= dat1_reg;
  end

  assign rise = clk2_reg && !clk3_reg;
  assign reqRead = hdr_reg[0];
  assign reqSpace = hdr_reg[1];
  assign reqAddr = hdr_reg[12:2];
  assign wrData = dat_reg;
  assign wrStb = wrStb_reg;
  assign progDataPinOut = out_reg[0];
  assign progDataPinOe = oe_reg;

  // -----------------------------------------------------------------
  // frame counter and input shifting
  // -----------------------------------------------------------------
  // R11 - writes of both memories
  always_ff @(posedge sys_clk) begin
    if (rst || !linkActive) begin
      cnt_reg <= 5'h00;
      hdr_reg <= 13'h0000;
      dat_reg <= 16'h0000;
      hdrDone_reg <= 1'b0;
      wrStb_reg <= 1'b0;
    end else begin
      hdrDone_reg <= 1'b0;
      wrStb_reg <= 1'b0;
      if (rise) begin
        if (cnt_reg < `PMT_HDR_BITS) begin
          hdr_reg <= {dat2_reg, hdr_reg[12:1]};
        end else begin
          dat_reg <= {dat2_reg, dat_reg[15:1]};
        end
        if (cnt_reg == `PMT_HDR_BITS - 5'd1) begin
          hdrDone_reg <= 1'b1;
        end
        if (cnt_reg == `PMT_FRAME_BITS - 5'd1) begin
          cnt_reg <= 5'h00;
          wrStb_reg <= !hdr_reg[0];
        end else begin
          cnt_reg <= cnt_reg + 5'd1;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // read-back driver
  // -----------------------------------------------------------------
  // R10 - drive data pin back
  // bits change a few cycles after the seen rise, well inside the hold window
  always_ff @(posedge sys_clk) begin
    if (rst || !linkActive) begin
      out_reg <= 16'h0000;
      oe_reg <= 1'b0;
    end else if (hdrDone_reg && reqRead) begin
      out_reg <= rdWord;
      oe_reg <= 1'b1;
    end else if (rise && oe_reg) begin
      out_reg <= {1'b0, out_reg[15:1]};
      if (cnt_reg == `PMT_FRAME_BITS - 5'd1) begin
        oe_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  icp_oe_gate_a: assert property (progDataPinOe |-> linkActive && reqRead) // R10
    else $error("data pin driven outside a read frame");
  icp_read_load_a: assert property ( // R10
    hdrDone_reg && reqRead && linkActive |=> progDataPinOe && progDataPinOut == $past(rdWord[0]))
    else $error("read word not loaded after header");
  icp_wr_strobe_a: assert property ( // R11
    wrStb |-> $past(rise) && $past(cnt_reg) == `PMT_FRAME_BITS - 5'd1 && !reqRead)
    else $error("write strobe outside frame end");

endmodule

// file: sim/pmt_programmer.sv
// serial programmer model: reset pin, link clock and shared data pin
// assumes the bench resolves the data wire from both enables and feeds it back
`timescale 1ns/1ps

module pmt_programmer (
  output logic resetPinN,
  output logic clkPin,
  output logic dataOut,
  output logic dataOe,
  input wire logic dataWire
);
  // idle: device running, clock parked low between frames, data released
  initial begin
    resetPinN = 1'b1;
    clkPin = 1'b0;
    dataOut = 1'b0;
    dataOe = 1'b0;
  end

  // reset pin held low for programming
  task automatic hold(input logic low);
    resetPinN = !low;
  endtask

  // one frame: bit set in low phase, sampled on our own rising edge
  task automatic frame(input logic rd, input logic ee, input logic [10:0] addr,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [28:0] bits;
    bits = {wdata, addr, ee, rd};
    rdata = 16'h0000;
    for (int i = 0; i < 29; i++) begin
      dataOe = (i < 13) || !rd; // release the pin while the device answers
      dataOut = bits[i];
      #160;
      clkPin = 1'b1;
      if (rd && i >= 13) rdata[i - 13] = dataWire;
      #160;
      clkPin = 1'b0;
    end
    dataOe = 1'b0;
    #1000; // slow link: let the memory write land before the next frame
  endtask
endmodule

// file: sim/pmt_table_read_tb.sv
// self-checking bench for the program memory table-read block
// assumes the 2K x 15 variant and a programmer model on the link pins
`timescale 1ns/1ps

module pmt_table_read_tb;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [14:0] fetchWord;
  logic [10:0] fetchAddr;
  logic fetchValid, tableStall, progMode, dmWrEn, progDataPinOut, progDataPinOe, eeWrEn;
  logic jumpEn = 1'b0;
  logic [10:0] jumpAddr = 11'h000;
  logic tblRdReq = 1'b0;
  pmt_pkg::pmt_mode_t tblRdMode = pmt_pkg::PMT_MODE_FULL;
  logic [7:0] tblDestAddr = 8'h00;
  logic [7:0] dmWrAddr, dmWrData, sfrRdData, eeAddr, eeWrData;
  logic sfrWrEn = 1'b0;
  logic sfrRdEn = 1'b0;
  logic [7:0] sfrWrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic [7:0] sfrRdAddr = 8'h00;
  logic [7:0] ee [256];
  logic resetPinN, clkPin, pOut, pOe, dataWire;
  logic lastWire = 1'b0;
  int mismatches = 0;
  int n_checks = 0;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  // undriven wire toggles every cycle so a stale value never passes
  // an unknown enable counts as released, so the toggle never locks at X
  assign dataWire = (progDataPinOe === 1'b1) ? progDataPinOut :
    ((pOe === 1'b1) ? pOut : ~lastWire);
  always @(posedge sys_clk) lastWire <= dataWire;

  // eeprom array behind the block
  always @(posedge sys_clk) if (eeWrEn) ee[eeAddr] <= eeWrData;

  pmt_table_read #(.LARGE_VARIANT(1'b1)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .externalResetPinN(resetPinN), .fetchWord(fetchWord), .fetchAddr(fetchAddr),
    .fetchValid(fetchValid), .tableStall(tableStall), .progMode(progMode),
    .jumpEn(jumpEn), .jumpAddr(jumpAddr), .tblRdReq(tblRdReq), .tblRdMode(tblRdMode),
    .tblDestAddr(tblDestAddr), .dmWrEn(dmWrEn), .dmWrAddr(dmWrAddr), .dmWrData(dmWrData),
    .sfrWrEn(sfrWrEn), .sfrWrAddr(sfrWrAddr), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
    .sfrRdAddr(sfrRdAddr), .sfrRdData(sfrRdData), .progClockPin(clkPin),
    .progDataPinIn(dataWire), .progDataPinOut(progDataPinOut),
    .progDataPinOe(progDataPinOe), .eeWrEn(eeWrEn), .eeAddr(eeAddr),
    .eeWrData(eeWrData), .eeRdData(ee[eeAddr]));

  pmt_programmer prog_u (.resetPinN(resetPinN), .clkPin(clkPin), .dataOut(pOut),
    .dataOe(pOe), .dataWire(dataWire));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic lost(input string what);
    mismatches++;
    $display("MISMATCH %s expected 1 seen timeout", what);
    close_out();
  endtask

  // strobes get one idle cycle so no signal is set twice in a step
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfrWrEn = 1'b1;
    sfrWrAddr = a;
    sfrWrData = d;
    @(negedge sys_clk) sfrWrEn = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    sfrRdEn = 1'b1;
    sfrRdAddr = a;
    @(negedge sys_clk) sfrRdEn = 1'b0;
    check(what, sfrRdData, exp);
    @(negedge sys_clk);
  endtask

  task automatic jmp(input logic [10:0] a);
    jumpAddr = a;
    jumpEn = 1'b1;
    @(negedge sys_clk) jumpEn = 1'b0;
    check("jump dummy", fetchValid, 1'b0);
    @(negedge sys_clk);
    check("jump target", fetchAddr, a);
  endtask

  // one table read; a pointer write rides in the stall cycle
  task automatic tbl(input pmt_pkg::pmt_mode_t m, input logic [7:0] dest,
                     input logic [7:0] nextLo, input logic [14:0] word);
    tblRdMode = m;
    tblDestAddr = dest;
    tblRdReq = 1'b1;
    @(negedge sys_clk) tblRdReq = 1'b0;
    check("stall", tableStall, 1'b1);
    sfrWrEn = 1'b1;
    sfrWrAddr = 8'h07;
    sfrWrData = nextLo;
    @(negedge sys_clk) sfrWrEn = 1'b0;
    check("dmWrEn", dmWrEn, 1'b1);
    check("dmWrAddr", dmWrAddr, dest);
    check("dmWrData", dmWrData, word[7:0]);
    check("fetch held", fetchValid, 1'b0);
    check("stall end", tableStall, 1'b0);
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check("first valid", fetchValid, 1'b1);
    check("first addr", fetchAddr, 11'h000);
    @(negedge sys_clk);
    check("next addr", fetchAddr, 11'h001);
    sfr_chk(8'h07, 8'h00, "ptrLow");
    sfr_chk(8'h09, 8'h00, "ptrHigh");
    sfr_chk(8'h08, 8'h00, "highByte");
    $display("test reset done");
  endtask

  task automatic t_prog();
    logic [15:0] rd;
    int k;
    prog_u.hold(1'b1);
    for (k = 0; k < 10 && progMode !== 1'b1; k++) @(negedge sys_clk);
    if (progMode !== 1'b1) lost("progMode");
    check("no fetch in prog", fetchValid, 1'b0);
    prog_u.frame(1'b0, 1'b0, 11'h705, 16'h1A2B, rd);
    prog_u.frame(1'b0, 1'b0, 11'h706, 16'hFFFF, rd);
    prog_u.frame(1'b0, 1'b0, 11'h010, 16'h0C3C, rd);
    prog_u.frame(1'b0, 1'b1, 11'h033, 16'h00C3, rd);
    check("ee write", ee[8'h33], 8'hC3);
    prog_u.frame(1'b1, 1'b0, 11'h706, 16'h0000, rd);
    check("prog read", rd, 16'h7FFF);
    prog_u.frame(1'b1, 1'b1, 11'h033, 16'h0000, rd);
    check("ee read", rd, 16'h00C3);
    @(negedge sys_clk) prog_u.hold(1'b0);
    for (k = 0; k < 20 && fetchValid !== 1'b1; k++) @(negedge sys_clk);
    if (fetchValid !== 1'b1) lost("fetchValid");
    check("vector after prog", fetchAddr, 11'h000);
    $display("test programming done");
  endtask

  task automatic t_fetch();
    jmp(11'h010);
    check("fetch word", fetchWord, 15'h0C3C);
    jmp(11'h300);
    sfrWrEn = 1'b1;
    sfrWrAddr = 8'h06;
    sfrWrData = 8'h80;
    @(negedge sys_clk) sfrWrEn = 1'b0;
    check("pc low dummy", fetchValid, 1'b0);
    @(negedge sys_clk);
    check("pc low valid", fetchValid, 1'b1);
    check("pc low page", fetchAddr, 11'h380);
    sfr_chk(8'h06, 8'h80, "pc low read");
    $display("test fetch done");
  endtask

  task automatic t_table();
    sfr_wr(8'h07, 8'h05);
    sfr_wr(8'h09, 8'h07);
    // back to back: latched 705, then full pointers 706
    tbl(pmt_pkg::PMT_MODE_LAST, 8'h40, 8'h06, 15'h1A2B);
    tbl(pmt_pkg::PMT_MODE_FULL, 8'h41, 8'h10, 15'h7FFF);
    @(negedge sys_clk);
    check("fetch resumes", fetchValid, 1'b1);
    sfr_chk(8'h08, 8'h7F, "high 706");
    sfr_wr(8'h08, 8'h55);
    sfr_chk(8'h08, 8'h7F, "high kept");
    sfr_chk(8'h0A, 8'h00, "unmapped read");
    jmp(11'h005);
    tbl(pmt_pkg::PMT_MODE_PAGE, 8'h42, 8'h10, 15'h0C3C);
    @(negedge sys_clk);
    sfr_chk(8'h08, 8'h0C, "high 010");
    $display("test table done");
  endtask

  initial begin
    t_reset();
    t_prog();
    t_fetch();
    t_table();
    t_reset();
    close_out();
  end
endmodule
